// *** logic/ssfll_core.sv ***
// spindle speed loop counters, charge pump pulses, pwm on-time and window
//
// Notes on behaviour
// - window opens 6.4 us after turn-on
// - short on-time: window opens just before turn-off
// - two bits select one of four minimum on-times
// - minimum on-time counted from internal clock
// - commutation slew bit: slow when set in pwm mode
// - chopping slew bit: fast when set in pwm mode
// - reference clock divided by five
// - 12-bit coarse counter, every 64 ticks, stops
// - 11-bit fine counter, every 4 ticks
// - reload values split across three registers
// - each feedback pulse loads coarse counter
// - coarse zero loads and starts fine counter
// - fine counts past zero to negated reload
// - fine zero crossing ends reference period
// - early feedback gives down pulse of difference
// - late feedback gives up pulse of difference
// - pulse width limited by fine reload
// - up drives source, down drives sink
// - test bits force source and sink
// - one bit selects pump current magnitude
// - feedback prescaled by one, four or six
// - comparison holds for any feedback timing
// - mode bit selects pwm or linear control
// - feedback from tach divided by three or index
`timescale 1ns/1ps
`default_nettype none

module ssfll_core
	import ssfll_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire ssfll_pins_type pinsIn,
	output ssfll_drive_type drive
);

	// =========================================================
	// types and state
	typedef enum logic [1:0] {
		FLL_IDLE,
		FLL_COARSE,
		FLL_FINE,
		FLL_STOP
	} ssfll_fll_type;

	typedef enum logic [1:0] {
		PWM_OFF,
		PWM_ON,
		PWM_LAST
	} ssfll_pwm_type;

	ssfll_fll_type fllState_q;
	ssfll_pwm_type pwmState_q;
	logic [7:0] regFile_q [16];
	logic wrPend_q;
	logic [IDX_W-1:0] wrIdx_q;
	logic [31:0] rdData_q;
	ssfll_pins_type syncA_q;
	ssfll_pins_type syncB_q;
	ssfll_pins_type prev_q;
	logic [2:0] refDiv_q;
	logic [5:0] sub_q;
	logic [1:0] tachDiv_q;
	logic [2:0] preCnt_q;
	logic [COARSE_W-1:0] coarseCnt_q;
	logic [FINE_W:0] fineCnt_q;
	logic [FINE_W-1:0] downCnt_q;
	logic [TMR_W-1:0] onTimer_q;
	logic zcSeen_q;
	ssfll_drive_type drive_q;

	// =========================================================
	// register decode
	function automatic logic isWritable(input logic [IDX_W-1:0] idx);
		case (idx)
			REG_SPIN_IDX, REG_OPT_IDX, REG_COARSE_IDX, REG_SPLIT_IDX,
			REG_FINE_IDX, REG_PUMP_IDX, REG_SLEW_IDX: isWritable = 1'b1;
			default: isWritable = 1'b0;
		endcase
	endfunction

	logic addrPhase;
	logic [IDX_W-1:0] addrIdx;
	logic [7:0] spinReg;
	logic [7:0] optReg;
	logic [7:0] pumpReg;
	logic [7:0] slewReg;
	logic [COARSE_W-1:0] coarseReload;
	logic [FINE_W-1:0] fineReload;
	logic [7:0] statusByte;
	logic [7:0] readByte;

	assign addrPhase = hsel && htrans[1] && hready;
	// word aligned: low two address bits are ignored
	assign addrIdx = haddr[IDX_W+1:2];
	assign spinReg = regFile_q[REG_SPIN_IDX[3:0]];
	assign optReg = regFile_q[REG_OPT_IDX[3:0]];
	assign pumpReg = regFile_q[REG_PUMP_IDX[3:0]];
	assign slewReg = regFile_q[REG_SLEW_IDX[3:0]];
	assign coarseReload = {regFile_q[REG_COARSE_IDX[3:0]],
		regFile_q[REG_SPLIT_IDX[3:0]][7:4]};
	assign fineReload = {regFile_q[REG_SPLIT_IDX[3:0]][2:0],
		regFile_q[REG_FINE_IDX[3:0]]};
	assign statusByte = {1'b0, fllState_q, drive_q.pumpSourceOn,
		drive_q.pumpSinkOn, drive_q.highSideOn, drive_q.zcWindowOpen,
		zcSeen_q};

	always_comb begin
		if (addrIdx == REG_STATUS_IDX) begin
			readByte = statusByte;
		end else if (isWritable(addrIdx)) begin
			readByte = regFile_q[addrIdx[3:0]];
		end else begin
			readByte = 8'h00;
		end
	end

	// =========================================================
	// ahb-lite slave: zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdData_q;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wrPend_q <= 1'b0;
			wrIdx_q <= '0;
		end else begin
			wrPend_q <= addrPhase && hwrite && isWritable(addrIdx);
			wrIdx_q <= addrIdx;
		end
	end

	// read data is latched in the address phase so it comes from a flop
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdData_q <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			rdData_q <= {24'h00_0000, readByte};
		end
	end

	// only the low byte is stored; upper lanes read back as zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int i = 0; i < 16; i++) begin
				regFile_q[i] <= REG_RESET;
			end
		end else if (wrPend_q) begin
			regFile_q[wrIdx_q[3:0]] <= hwdata[7:0];
		end
	end

	// =========================================================
	// pin synchronisers and edge detect
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			syncA_q <= '0;
			syncB_q <= '0;
			prev_q <= '0;
		end else begin
			syncA_q <= pinsIn;
			syncB_q <= syncA_q;
			prev_q <= syncB_q;
		end
	end

	logic tachRise;
	logic indexRise;
	assign tachRise = syncB_q.commutationTach && !prev_q.commutationTach;
	assign indexRise = syncB_q.indexPulse && !prev_q.indexPulse;

	// =========================================================
	// feedback selection and prescaler
	logic tach3Pulse;
	logic [2:0] preDiv;
	logic fbPulse;

	assign tach3Pulse = tachRise && (tachDiv_q == TACH_DIV_LAST);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tachDiv_q <= 2'h0;
		end else if (tachRise) begin
			tachDiv_q <= (tachDiv_q == TACH_DIV_LAST) ? 2'h0 :
				tachDiv_q + 2'h1;
		end
	end

	always_comb begin
		if (spinReg[CYCLE_TYPE_BIT]) begin
			preDiv = ELEC_DIV;
		end else if (optReg[POLE12_BIT]) begin
			preDiv = MECH_DIV_12P;
		end else begin
			preDiv = MECH_DIV_8P;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			preCnt_q <= 3'h0;
		end else if (tach3Pulse) begin
			preCnt_q <= (preCnt_q >= preDiv - 3'h1) ? 3'h0 :
				preCnt_q + 3'h1;
		end
	end

	// index input is already once per turn and bypasses the prescaler
	assign fbPulse = spinReg[FB_SOURCE_BIT] ? indexRise :
		(tach3Pulse && preCnt_q >= preDiv - 3'h1);

	// =========================================================
	// reference dividers
	logic freqTick;
	logic coarseTick;
	logic fineTick;

	assign freqTick = (refDiv_q == REF_DIV_LAST);
	assign coarseTick = freqTick && (sub_q == COARSE_SUB_LAST);
	assign fineTick = freqTick && (sub_q[1:0] == FINE_SUB_LAST);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			refDiv_q <= 3'h0;
		end else begin
			refDiv_q <= freqTick ? 3'h0 : refDiv_q + 3'h1;
		end
	end

	// restart the sub-divider on each feedback edge so every period
	// is measured from the same phase
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sub_q <= 6'h00;
		end else if (fbPulse) begin
			sub_q <= 6'h00;
		end else if (freqTick) begin
			sub_q <= sub_q + 6'h01;
		end
	end

	// =========================================================
	// coarse and fine period counters
	logic [FINE_W:0] fineStop;
	logic fineAtStop;
	logic fineNextStop;
	logic upPulse;
	logic downPulse;

	assign fineStop = (FINE_W+1)'(~{1'b0, fineReload} + 1'b1);
	assign fineAtStop = (fineCnt_q == fineStop);
	// stop on the tick that lands on the negated reload, so the up pulse
	// never runs longer than the fine reload
	assign fineNextStop = ((fineCnt_q - 1'b1) == fineStop);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fllState_q <= FLL_IDLE;
			coarseCnt_q <= '0;
			fineCnt_q <= '0;
		end else if (fbPulse) begin
			fllState_q <= FLL_COARSE;
			coarseCnt_q <= coarseReload;
		end else begin
			case (fllState_q)
				FLL_COARSE: begin
					if (coarseCnt_q == '0) begin
						fllState_q <= FLL_FINE;
						fineCnt_q <= {1'b0, fineReload};
					end else if (coarseTick) begin
						coarseCnt_q <= coarseCnt_q - 1'b1;
					end
				end
				FLL_FINE: begin
					if (fineTick) begin
						if (fineAtStop) begin
							fllState_q <= FLL_STOP;
						end else begin
							fineCnt_q <= fineCnt_q - 1'b1;
							if (fineNextStop) begin
								fllState_q <= FLL_STOP;
							end
						end
					end
				end
				default: begin
					fllState_q <= fllState_q;
				end
			endcase
		end
	end

	// down: remaining reference time when feedback arrives early,
	// measured in fine ticks; an edge in the coarse range takes the
	// full fine reload as the largest pulse
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			downCnt_q <= '0;
		end else if (fbPulse && fllState_q == FLL_COARSE) begin
			downCnt_q <= fineReload;
		end else if (fbPulse && fllState_q == FLL_FINE &&
				!fineCnt_q[FINE_W]) begin
			downCnt_q <= fineCnt_q[FINE_W-1:0];
		end else if (fineTick && downCnt_q != '0) begin
			downCnt_q <= downCnt_q - 1'b1;
		end
	end

	assign downPulse = (downCnt_q != '0);
	// up: from the fine zero crossing to the feedback edge, cut at stop
	assign upPulse = (fllState_q == FLL_FINE) &&
		(fineCnt_q[FINE_W] || fineCnt_q == '0);

	// =========================================================
	// pwm on-time, minimum on-time and zero-cross window
	logic pwmMode;
	logic [TMR_W-1:0] minOnCyc;
	logic minOnDone;
	logic delayDone;
	logic offRequest;

	assign pwmMode = spinReg[PWM_MODE_BIT];

	// fixed cycle counts: independent of the speed reference setting
	always_comb begin
		case ({optReg[ON_TIME_HI_BIT], optReg[ON_TIME_LO_BIT]})
			2'b00: minOnCyc = MIN_ON_00_CYC;
			2'b01: minOnCyc = MIN_ON_01_CYC;
			2'b10: minOnCyc = MIN_ON_10_CYC;
			default: minOnCyc = MIN_ON_11_CYC;
		endcase
	end

	assign minOnDone = (onTimer_q >= minOnCyc);
	assign delayDone = (onTimer_q >= WIN_DELAY_CYC);
	assign offRequest = syncB_q.currentTrip && minOnDone;

	always_ff @(posedge ref_clk) begin
		if (rst || !pwmMode) begin
			pwmState_q <= PWM_OFF;
		end else begin
			case (pwmState_q)
				PWM_OFF: begin
					if (syncB_q.offTimeDone) begin
						pwmState_q <= PWM_ON;
					end
				end
				PWM_ON: begin
					if (offRequest && delayDone) begin
						pwmState_q <= PWM_OFF;
					end else if (offRequest) begin
						pwmState_q <= PWM_LAST;
					end
				end
				default: begin
					pwmState_q <= PWM_OFF;
				end
			endcase
		end
	end

	// saturating timer; the largest count needed fits its width
	always_ff @(posedge ref_clk) begin
		if (rst || pwmState_q != PWM_ON) begin
			onTimer_q <= '0;
		end else if (onTimer_q != '1) begin
			onTimer_q <= onTimer_q + 1'b1;
		end
	end

	logic windowOpen;
	assign windowOpen = (pwmState_q == PWM_LAST) ||
		(pwmState_q == PWM_ON && delayDone && !zcSeen_q);

	always_ff @(posedge ref_clk) begin
		if (rst || pwmState_q == PWM_OFF) begin
			zcSeen_q <= 1'b0;
		end else if (windowOpen && syncB_q.zeroCross) begin
			zcSeen_q <= 1'b1;
		end
	end

	// =========================================================
	// registered pin drive
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			drive_q <= '0;
		end else begin
			drive_q.pumpSourceOn <= upPulse ||
				pumpReg[SOURCE_FORCE_BIT];
			drive_q.pumpSinkOn <= downPulse ||
				pumpReg[SINK_FORCE_BIT];
			drive_q.pumpCurrentHigh <= pumpReg[PUMP_CURRENT_BIT];
			drive_q.highSideOn <= pwmState_q != PWM_OFF;
			drive_q.zcWindowOpen <= windowOpen;
			drive_q.commutationSlowSlew <= pwmMode &&
				slewReg[COM_SLOPE_BIT];
			drive_q.chopFastSlew <= pwmMode &&
				pumpReg[CHOP_SLOPE_BIT];
			drive_q.linearMode <= !pwmMode;
		end
	end

	assign drive = drive_q;

	logic unusedBits;
	assign unusedBits = ^{hsize, haddr[1:0], hwdata[31:8], syncB_q.offTimeDone};

endmodule

`default_nettype wire

// *** shared/ssfll_pkg.sv ***
// constants and carrier types for the spindle speed loop and pwm timing
package ssfll_pkg;

	// =========================================================
	// timebase
	localparam int CLK_PERIOD_NS = 25;
	localparam int WIN_DELAY_NS = 6400;
	localparam int MIN_ON_00_NS = 5900;
	localparam int MIN_ON_01_NS = 1400;
	localparam int MIN_ON_10_NS = 12000;
	localparam int MIN_ON_11_NS = 5210;
	localparam int TMR_W = 9;
	localparam logic [TMR_W-1:0] WIN_DELAY_CYC =
		TMR_W'((WIN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] MIN_ON_00_CYC =
		TMR_W'((MIN_ON_00_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] MIN_ON_01_CYC =
		TMR_W'((MIN_ON_01_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] MIN_ON_10_CYC =
		TMR_W'((MIN_ON_10_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] MIN_ON_11_CYC =
		TMR_W'((MIN_ON_11_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// =========================================================
	// speed loop dividers and counter widths
	localparam logic [2:0] REF_DIV_LAST = 3'h4;
	localparam logic [5:0] COARSE_SUB_LAST = 6'h3F;
	localparam logic [1:0] FINE_SUB_LAST = 2'h3;
	localparam logic [1:0] TACH_DIV_LAST = 2'h2;
	localparam logic [2:0] ELEC_DIV = 3'h1;
	localparam logic [2:0] MECH_DIV_8P = 3'h4;
	localparam logic [2:0] MECH_DIV_12P = 3'h6;
	localparam int COARSE_W = 12;
	localparam int FINE_W = 11;

	// =========================================================
	// register indices; byte address is four times the index
	localparam int ADDR_W = 8;
	localparam int IDX_W = 5;
	localparam logic [IDX_W-1:0] REG_SPIN_IDX = 5'h02;
	localparam logic [IDX_W-1:0] REG_OPT_IDX = 5'h03;
	localparam logic [IDX_W-1:0] REG_COARSE_IDX = 5'h04;
	localparam logic [IDX_W-1:0] REG_SPLIT_IDX = 5'h05;
	localparam logic [IDX_W-1:0] REG_FINE_IDX = 5'h06;
	localparam logic [IDX_W-1:0] REG_PUMP_IDX = 5'h08;
	localparam logic [IDX_W-1:0] REG_SLEW_IDX = 5'h0B;
	localparam logic [IDX_W-1:0] REG_STATUS_IDX = 5'h10;
	localparam logic [7:0] REG_RESET = 8'h00;

	// =========================================================
	// field positions
	localparam int CYCLE_TYPE_BIT = 5;
	localparam int PWM_MODE_BIT = 6;
	localparam int FB_SOURCE_BIT = 7;
	localparam int ON_TIME_HI_BIT = 1;
	localparam int ON_TIME_LO_BIT = 2;
	localparam int POLE12_BIT = 3;
	localparam int CHOP_SLOPE_BIT = 0;
	localparam int PUMP_CURRENT_BIT = 1;
	localparam int SOURCE_FORCE_BIT = 6;
	localparam int SINK_FORCE_BIT = 7;
	localparam int COM_SLOPE_BIT = 3;

	// =========================================================
	// carriers
	typedef struct packed {
		logic zeroCross;
		logic currentTrip;
		logic offTimeDone;
		logic indexPulse;
		logic commutationTach;
	} ssfll_pins_type;

	typedef struct packed {
		logic pumpSourceOn;
		logic pumpSinkOn;
		logic pumpCurrentHigh;
		logic highSideOn;
		logic zcWindowOpen;
		logic commutationSlowSlew;
		logic chopFastSlew;
		logic linearMode;
	} ssfll_drive_type;

endpackage

// *** sim/ssfll_core_assertions.sv ***
// assertion checker on the ports of the spindle speed loop core
`timescale 1ns/1ps
`default_nettype none
module ssfll_core_assertions
	import ssfll_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire ssfll_pins_type pinsIn,
	input wire ssfll_drive_type drive
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// helper
	// length of the running high-side on interval
	logic [9:0] onCnt_q;
	always_ff @(posedge ref_clk) begin
		if (rst || !drive.highSideOn) begin
			onCnt_q <= 10'h000;
		end else begin
			onCnt_q <= onCnt_q + 10'h001;
		end
	end
	// ==========================================================
	// properties
	sequence s_on_long;
		onCnt_q >= 10'h0FE;
	endsequence
	sequence s_off_soon;
		##[0:2] !drive.highSideOn;
	endsequence
	property p_win_open;
		$rose(drive.zcWindowOpen) |-> s_on_long or s_off_soon;
	endproperty
	a_win_open: assert property (p_win_open)
		else $error("window opened too early");
	property p_win_short;
		$rose(drive.zcWindowOpen) && onCnt_q < 10'h0FE |->
			##1 !drive.zcWindowOpen && !drive.highSideOn;
	endproperty
	a_win_short: assert property (p_win_short)
		else $error("window left open after turn-off");
	property p_win_zc;
		$rose(pinsIn.zeroCross) && drive.zcWindowOpen |->
			##[1:6] !drive.zcWindowOpen;
	endproperty
	a_win_zc: assert property (p_win_zc)
		else $error("window not closed by zero cross");
	property p_win_on;
		drive.zcWindowOpen |-> drive.highSideOn || $past(drive.highSideOn);
	endproperty
	a_win_on: assert property (p_win_on)
		else $error("window open while driver idle");
	property p_min_on;
		$fell(drive.highSideOn) && !drive.linearMode |->
			onCnt_q >= 10'h038;
	endproperty
	a_min_on: assert property (p_min_on)
		else $error("on-time below shortest minimum");
	property p_lin_off;
		drive.linearMode [*3] |-> !drive.highSideOn;
	endproperty
	a_lin_off: assert property (p_lin_off)
		else $error("chopping in linear mode");
	property p_chop_slew;
		drive.chopFastSlew |-> !drive.linearMode;
	endproperty
	a_chop_slew: assert property (p_chop_slew)
		else $error("chop slope set outside pwm mode");
	property p_com_slew;
		drive.commutationSlowSlew |-> !drive.linearMode;
	endproperty
	a_com_slew: assert property (p_com_slew)
		else $error("commutation slope set outside pwm mode");
	property p_bus_ok;
		hreadyout && !hresp;
	endproperty
	a_bus_ok: assert property (p_bus_ok)
		else $error("bus wait or error response");
	property p_rd_hi;
		hrdata[31:8] == 24'h000000;
	endproperty
	a_rd_hi: assert property (p_rd_hi)
		else $error("read data upper bits set");
endmodule
`default_nettype wire

// *** sim/ssfll_core_tb.sv ***
// self-checking bench for the spindle speed loop core
`timescale 1ns/1ps
`default_nettype none
module ssfll_core_tb
	import ssfll_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [ADDR_W-1:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	ssfll_pins_type pinsIn;
	ssfll_drive_type drive;
	logic zcEnable = 1'b0;
	int error_cnt = 0;
	int checks_done = 0;
	always #12.5 ref_clk = ~ref_clk;
	ssfll_core dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .pinsIn(pinsIn), .drive(drive));
	ssfll_motor_model motor (.ref_clk(ref_clk), .drive(drive),
		.zcEnable(zcEnable), .pinsIn(pinsIn));
	// ==========================================================
	// common tasks
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic fail_wait();
		error_cnt++;
		$display("[FAIL] %0t wait ran out", $time);
		end_sim();
	endtask
	function automatic logic pick(input int sel);
		case (sel)
			0: return drive.pumpSourceOn;
			1: return drive.pumpSinkOn;
			2: return drive.highSideOn;
			default: return drive.zcWindowOpen;
		endcase
	endfunction
	task automatic wait_for(input int sel, input logic v, output int n);
		n = 0;
		while (pick(sel) !== v && n < 20000) begin
			@(posedge ref_clk);
			n++;
		end
		if (pick(sel) !== v) fail_wait();
	endtask
	task automatic bus_wait();
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (hreadyout !== 1'b1) fail_wait();
	endtask
	// one single word transfer; the data phase carries the byte
	task automatic ahb(input logic wr, input logic [IDX_W-1:0] idx,
		input logic [7:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {1'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		bus_wait();
		htrans <= 2'h0;
		hwdata <= {24'h000000, wd};
		bus_wait();
		rd = hrdata;
	endtask
	task automatic wreg(input logic [IDX_W-1:0] idx, input logic [7:0] d);
		logic [31:0] rd;
		ahb(1'b1, idx, d, rd);
	endtask
	task automatic rreg(input logic [IDX_W-1:0] idx,
		input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] rd;
		ahb(1'b0, idx, 8'h00, rd);
		check(rd & mask, exp);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_regs();
		logic [IDX_W-1:0] ids [8];
		ids = '{REG_SPIN_IDX, REG_OPT_IDX, REG_COARSE_IDX, REG_SPLIT_IDX,
			REG_FINE_IDX, REG_PUMP_IDX, REG_SLEW_IDX, REG_STATUS_IDX};
		foreach (ids[i]) rreg(ids[i], 32'hFFFFFFFF, 32'h0);
		check(32'(drive.linearMode), 32'h1);
		wreg(REG_COARSE_IDX, 8'hA5);
		wreg(REG_SPLIT_IDX, 8'hF7);
		rreg(REG_COARSE_IDX, 32'hFF, 32'hA5);
		rreg(REG_SPLIT_IDX, 32'hF7, 32'hF7);
		wreg(REG_STATUS_IDX, 8'hFF);
		rreg(REG_STATUS_IDX, 32'hFFFFFFFF, 32'h0);
		wreg(5'h09, 8'h5A);
		rreg(5'h09, 32'hFFFFFFFF, 32'h0);
	endtask
	task automatic t_modes();
		for (int k = 0; k < 4; k++) begin
			wreg(REG_SPIN_IDX, {1'h0, k[1], 6'h00});
			wreg(REG_PUMP_IDX, {k[1], k[0], 4'h0, k[1], k[0]});
			wreg(REG_SLEW_IDX, {4'h0, k[1], 3'h0});
			repeat (2) @(posedge ref_clk);
			check(32'(drive.linearMode), 32'(!k[1]));
			check(32'(drive.chopFastSlew), 32'(k[1] & k[0]));
			check(32'(drive.commutationSlowSlew), 32'(k[1]));
			check(32'(drive.pumpCurrentHigh), 32'(k[1]));
			check(32'(drive.pumpSourceOn), 32'(k[0]));
			check(32'(drive.pumpSinkOn), 32'(k[1]));
		end
		wreg(REG_PUMP_IDX, 8'h00);
		wreg(REG_SLEW_IDX, 8'h00);
		wreg(REG_SPIN_IDX, 8'h00);
	endtask
	// coarse reload 1 (320 clocks), fine reload 8 (160 clocks)
	task automatic t_fll();
		int n;
		int w;
		int t;
		wreg(REG_COARSE_IDX, 8'h00);
		wreg(REG_SPLIT_IDX, 8'h10);
		wreg(REG_FINE_IDX, 8'h08);
		wreg(REG_SPIN_IDX, 8'h80);
		check(32'(drive.pumpSourceOn | drive.pumpSinkOn), 32'h0);
		motor.pulse(0, 1);
		repeat (392) @(posedge ref_clk);
		motor.pulse(0, 1);
		wait_for(1, 1'b1, n);
		wait_for(1, 1'b0, w);
		check(32'(w inside {[60:100]}), 32'h1);
		motor.pulse(0, 1);
		wait_for(1, 1'b1, n);
		wait_for(1, 1'b0, w);
		check(32'(w inside {[145:165]}), 32'h1);
		t = 8 + n + w;
		wait_for(0, 1'b1, n);
		check(32'(t + n inside {[470:500]}), 32'h1);
		wait_for(0, 1'b0, w);
		check(32'(w inside {[150:170]}), 32'h1);
		rreg(REG_STATUS_IDX, 32'h60, 32'h60);
	endtask
	task automatic t_pwm();
		int e[4] = '{236, 56, 480, 209};
		int a;
		int b;
		wreg(REG_SPIN_IDX, 8'h40);
		for (int k = 0; k < 4; k++) begin
			wreg(REG_OPT_IDX, {5'h00, k[0], k[1], 1'h0});
			wait_for(2, 1'b0, a);
			wait_for(2, 1'b1, a);
			wait_for(3, 1'b1, a);
			wait_for(2, 1'b0, b);
			check(32'(a + b inside {[e[k] - 2:e[k] + 4]}), 32'h1);
			check(32'(e[k] > 256 ? a inside {[250:260]} :
				a >= e[k] - 3), 32'h1);
		end
		wreg(REG_OPT_IDX, 8'h02);
		zcEnable <= 1'b1;
		wait_for(2, 1'b0, a);
		wait_for(2, 1'b1, a);
		wait_for(3, 1'b1, a);
		wait_for(3, 1'b0, b);
		check(32'(b inside {[20:30]}), 32'h1);
		check(32'(drive.highSideOn), 32'h1);
		zcEnable <= 1'b0;
		wreg(REG_SPIN_IDX, 8'h00);
		repeat (3) @(posedge ref_clk);
		check(32'(drive.highSideOn), 32'h0);
	endtask
	// prescale 1, 4 and 6 on the tach divided by three
	task automatic t_tach();
		int p;
		for (int m = 0; m < 3; m++) begin
			p = (m == 0) ? 1 : (m == 1) ? 4 : 6;
			rst <= 1'b1;
			repeat (2) @(posedge ref_clk);
			rst <= 1'b0;
			@(posedge ref_clk);
			wreg(REG_COARSE_IDX, 8'hFF);
			wreg(REG_OPT_IDX, (m == 2) ? 8'h08 : 8'h00);
			wreg(REG_SPIN_IDX, (m == 0) ? 8'h20 : 8'h00);
			motor.pulse(1, 3 * p - 1);
			repeat (4) @(posedge ref_clk);
			rreg(REG_STATUS_IDX, 32'h60, 32'h00);
			motor.pulse(1, 1);
			rreg(REG_STATUS_IDX, 32'h60, 32'h20);
		end
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_regs();
		t_modes();
		t_fll();
		t_pwm();
		t_tach();
		end_sim();
	end
endmodule
bind ssfll_core ssfll_core_assertions u_chk (.ref_clk(ref_clk), .rst(rst),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.pinsIn(pinsIn), .drive(drive));
`default_nettype wire

// *** sim/ssfll_motor_model.sv ***
// behavioural motor, current sense and off-time one-shot on the pins
`timescale 1ns/1ps
`default_nettype none
module ssfll_motor_model
	import ssfll_pkg::*;
(
	input wire logic ref_clk,
	input wire ssfll_drive_type drive,
	input wire logic zcEnable,
	output var ssfll_pins_type pinsIn
);
	int offCnt = 0;
	int winCnt = 0;
	initial pinsIn = '0;
	// ==========================================================
	// current loop
	// current trips at once, so the minimum on-time sets each pulse
	always @(posedge ref_clk) begin
		pinsIn.currentTrip <= drive.highSideOn;
		offCnt <= drive.highSideOn ? 0 : offCnt + 1;
		pinsIn.offTimeDone <= !drive.highSideOn && offCnt >= 40;
		winCnt <= drive.zcWindowOpen ? winCnt + 1 : 0;
		pinsIn.zeroCross <= zcEnable && winCnt >= 20;
	end
	// ==========================================================
	// feedback pulses: index when which is 0, tach otherwise
	task automatic pulse(input int which, input int n);
		repeat (n) begin
			pinsIn.indexPulse <= (which == 0);
			pinsIn.commutationTach <= (which != 0);
			repeat (4) @(posedge ref_clk);
			pinsIn.indexPulse <= 1'b0;
			pinsIn.commutationTach <= 1'b0;
			repeat (4) @(posedge ref_clk);
		end
	endtask
endmodule
`default_nettype wire
